// ---- inc/sls_defs.vh ----
// Purpose: Constants for the serial link setup block
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef SLS_DEFS_VH
`define SLS_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLS_OFS_SPEED       8'h00
`define SLS_OFS_ADDR        8'h04
`define SLS_OFS_PROTO       8'h08
`define SLS_OFS_FRAME       8'h0c
`define SLS_OFS_WAIT        8'h10
`define SLS_OFS_ACTIVE      8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLS_SPD_P2P_LSB     0
`define SLS_SPD_MD_LSB      4
`define SLS_ACT_P2P_LSB     0
`define SLS_ACT_MD_LSB      4
`define SLS_ACT_PROTO_LSB   8
`define SLS_ACT_FRAME_LSB   12
`define SLS_ACT_ADDR_LSB    16
`define SLS_ACT_FLAGS_LSB   24

// ----------------------------------------------------------------
// Reset values and ranges
// ----------------------------------------------------------------
`define SLS_RST_SPEED       3'h2
`define SLS_RST_ADDR        7'h01
`define SLS_RST_PROTO       2'h0
`define SLS_RST_FRAME       3'h0
`define SLS_RST_WAIT        14'h0000
`define SLS_PROTO_NATIVE    2'h0
`define SLS_PROTO_MB_P2P    2'h1
`define SLS_PROTO_MB_MD     2'h2
`define SLS_FRAME_MAX       3'h5
`define SLS_WAIT_MAX_MS     14'h2710
`define SLS_NATIVE_ADDR_MAX 7'h1f
`define SLS_SPEED_TOP       3'h7
`define SLS_SPEED_9600      3'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLS_CLK_HZ          100000000
`define SLS_MS_PER_S        1000
`define SLS_OVERSAMPLE      16
`define SLS_BAUD_BASE       2400
`define SLS_BAUD_57600      57600
`define SLS_BAUD_115200     115200
`define SLS_BAUD_230400     230400
`define SLS_DATA_BITS       4'h8

`endif

// ---- hw/sls_link_setup.v ----
// Purpose: Speed, address, protocol and framing setup for two serial links
// Assumes: AXI4-Lite master, 100 MHz aclk, ctrl_power_up from a pin
// Notes:   Settings written over the bus act only after a control power-up
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`include "sls_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sls_link_setup #(
  parameter CYC_PER_MS = `SLS_CLK_HZ / `SLS_MS_PER_S
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ctrl_power_up,
  input  wire        reply_request,
  output reg         reply_release,
  output reg         reply_waiting_r,
  output reg         p2p_tick16_r,
  output reg         p2p_bit_tick_r,
  output reg         md_tick16_r,
  output reg         md_bit_tick_r,
  output reg         p2p_modbus_en_r,
  output reg         md_modbus_en_r,
  output reg         addr_valid_r,
  output reg  [1:0]  parity_mode_r,
  output reg         two_stop_r,
  output wire [3:0]  data_bits
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] baud_of;
    input [2:0] code;
    begin
      case (code)
        3'h5:    baud_of = `SLS_BAUD_57600;
        3'h6:    baud_of = `SLS_BAUD_115200;
        3'h7:    baud_of = `SLS_BAUD_230400;
        default: baud_of = `SLS_BAUD_BASE << code;
      endcase
    end
  endfunction

  // Rounded divisor keeps every rate under 0.5 percent error at 100 MHz
  function [11:0] div16_of;
    input [2:0] code;
    reg   [31:0] b;
    reg   [31:0] d;
    begin
      b = baud_of(code);
      d = (`SLS_CLK_HZ + b * (`SLS_OVERSAMPLE / 2)) / (b * `SLS_OVERSAMPLE);
      div16_of = d[11:0];
    end
  endfunction

  // Native protocol has no top rate; code 7 falls back to 9600
  function [2:0] eff_code;
    input [2:0] code;
    input [1:0] proto;
    begin
      if (proto == `SLS_PROTO_NATIVE && code == `SLS_SPEED_TOP) begin
        eff_code = `SLS_SPEED_9600;
      end else begin
        eff_code = code;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pending (written) and active (latched) settings
  // ----------------------------------------------------------------
  reg [2:0]  pend_p2p_r;
  reg [2:0]  pend_md_r;
  reg [6:0]  pend_addr_r;
  reg [1:0]  pend_proto_r;
  reg [2:0]  pend_frame_r;
  reg [13:0] pend_wait_r;
  reg [2:0]  act_p2p_r;
  reg [2:0]  act_md_r;
  reg [6:0]  act_addr_r;
  reg [1:0]  act_proto_r;
  reg [2:0]  act_frame_r;
  reg [13:0] act_wait_r;
  reg        pwr_s1_r;
  reg        pwr_s2_r;
  reg        pwr_s3_r;
  wire       pwr_rise;

  assign pwr_rise  = pwr_s2_r & ~pwr_s3_r;
  assign data_bits = `SLS_DATA_BITS;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      pwr_s3_r <= 1'b0;
    end else begin
      pwr_s1_r <= ctrl_power_up;
      pwr_s2_r <= pwr_s1_r;
      pwr_s3_r <= pwr_s2_r;
    end
  end

  // Power-on reset loads defaults; later edits need a control power-up
  always @(posedge aclk) begin
    if (!aresetn) begin
      act_p2p_r   <= `SLS_RST_SPEED;
      act_md_r    <= `SLS_RST_SPEED;
      act_addr_r  <= `SLS_RST_ADDR;
      act_proto_r <= `SLS_RST_PROTO;
      act_frame_r <= `SLS_RST_FRAME;
      act_wait_r  <= `SLS_RST_WAIT;
    end else if (pwr_rise) begin
      act_p2p_r   <= pend_p2p_r;
      act_md_r    <= pend_md_r;
      act_addr_r  <= pend_addr_r;
      act_proto_r <= pend_proto_r;
      act_frame_r <= pend_frame_r;
      act_wait_r  <= pend_wait_r;
    end
  end

  // ----------------------------------------------------------------
  // Decoded link configuration
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      p2p_modbus_en_r <= 1'b0;
      md_modbus_en_r  <= 1'b0;
      addr_valid_r    <= 1'b1;
      parity_mode_r   <= 2'h0;
      two_stop_r      <= 1'b0;
    end else begin
      p2p_modbus_en_r <= act_proto_r == `SLS_PROTO_MB_P2P && act_addr_r != 7'h00;
      md_modbus_en_r  <= act_proto_r == `SLS_PROTO_MB_MD && act_addr_r != 7'h00;
      if (act_proto_r == `SLS_PROTO_NATIVE) begin
        addr_valid_r <= act_addr_r <= `SLS_NATIVE_ADDR_MAX;
      end else begin
        addr_valid_r <= act_addr_r != 7'h00;
      end
      // 0 even, 1 odd, 2 none; odd codes add the second stop bit
      parity_mode_r <= act_frame_r[2:1];
      two_stop_r    <= act_frame_r[0];
    end
  end

  // ----------------------------------------------------------------
  // Bit-rate generators, index 0 point-to-point, 1 multidrop
  // ----------------------------------------------------------------
  reg  [11:0] tick_cnt_r [0:1];
  reg  [3:0]  sub_cnt_r  [0:1];
  reg  [1:0]  tick_r;
  reg  [1:0]  bit_r;
  wire [11:0] div_p2p;
  wire [11:0] div_md;
  integer     li;

  assign div_p2p = div16_of(eff_code(act_p2p_r, act_proto_r));
  assign div_md  = div16_of(eff_code(act_md_r, act_proto_r));

  always @(posedge aclk) begin
    for (li = 0; li < 2; li = li + 1) begin
      if (!aresetn) begin
        tick_cnt_r[li] <= 12'h000;
        sub_cnt_r[li]  <= 4'h0;
        tick_r[li]     <= 1'b0;
        bit_r[li]      <= 1'b0;
      end else if (tick_cnt_r[li] >= ((li == 0) ? div_p2p : div_md) - 12'h001) begin
        tick_cnt_r[li] <= 12'h000;
        sub_cnt_r[li]  <= sub_cnt_r[li] + 4'h1;
        tick_r[li]     <= 1'b1;
        bit_r[li]      <= sub_cnt_r[li] == 4'hf;
      end else begin
        tick_cnt_r[li] <= tick_cnt_r[li] + 12'h001;
        tick_r[li]     <= 1'b0;
        bit_r[li]      <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      p2p_tick16_r   <= 1'b0;
      md_tick16_r    <= 1'b0;
      p2p_bit_tick_r <= 1'b0;
      md_bit_tick_r  <= 1'b0;
    end else begin
      p2p_tick16_r   <= tick_r[0];
      md_tick16_r    <= tick_r[1];
      p2p_bit_tick_r <= bit_r[0];
      md_bit_tick_r  <= bit_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Modbus reply wait
  // ----------------------------------------------------------------
  localparam integer MS_LAST_I = CYC_PER_MS - 1;
  localparam [16:0]  MS_LAST   = MS_LAST_I[16:0];
  reg [16:0] ms_cnt_r;
  reg [13:0] ms_left_r;

  // Requests that arrive while waiting are dropped; one reply at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      reply_waiting_r <= 1'b0;
      reply_release   <= 1'b0;
      ms_cnt_r        <= 17'h00000;
      ms_left_r       <= 14'h0000;
    end else begin
      reply_release <= 1'b0;
      if (!reply_waiting_r) begin
        if (reply_request && (p2p_modbus_en_r || md_modbus_en_r)) begin
          reply_waiting_r <= 1'b1;
          ms_cnt_r        <= 17'h00000;
          ms_left_r       <= act_wait_r;
        end
      end else if (ms_left_r == 14'h0000) begin
        reply_waiting_r <= 1'b0;
        reply_release   <= 1'b1;
      end else if (ms_cnt_r == MS_LAST) begin
        ms_cnt_r  <= 17'h00000;
        ms_left_r <= ms_left_r - 14'h0001;
      end else begin
        ms_cnt_r <= ms_cnt_r + 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg        aw_have_r;
  reg        w_have_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg        bad_wr;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Out-of-range protocol, frame and wait values are refused and the old setting kept; speed and address writes are always taken
  always @* begin
    case (aw_addr_r)
      `SLS_OFS_SPEED: bad_wr = 1'b0;
      `SLS_OFS_ADDR:  bad_wr = 1'b0;
      `SLS_OFS_PROTO: bad_wr = w_data_r[1:0] > `SLS_PROTO_MB_MD;
      `SLS_OFS_FRAME: bad_wr = w_data_r[2:0] > `SLS_FRAME_MAX;
      `SLS_OFS_WAIT:  bad_wr = w_data_r[13:0] > `SLS_WAIT_MAX_MS;
      default:        bad_wr = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      pend_p2p_r   <= `SLS_RST_SPEED;
      pend_md_r    <= `SLS_RST_SPEED;
      pend_addr_r  <= `SLS_RST_ADDR;
      pend_proto_r <= `SLS_RST_PROTO;
      pend_frame_r <= `SLS_RST_FRAME;
      pend_wait_r  <= `SLS_RST_WAIT;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (aw_have_r && w_have_r) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bad_wr ? 2'h2 : 2'h0;
        if (!bad_wr && aw_addr_r == `SLS_OFS_SPEED) begin
          pend_p2p_r <= w_data_r[`SLS_SPD_P2P_LSB +: 3];
          pend_md_r  <= w_data_r[`SLS_SPD_MD_LSB +: 3];
        end
        if (!bad_wr && aw_addr_r == `SLS_OFS_ADDR) begin
          pend_addr_r <= w_data_r[6:0];
        end
        if (!bad_wr && aw_addr_r == `SLS_OFS_PROTO) begin
          pend_proto_r <= w_data_r[1:0];
        end
        if (!bad_wr && aw_addr_r == `SLS_OFS_FRAME) begin
          pend_frame_r <= w_data_r[2:0];
        end
        if (!bad_wr && aw_addr_r == `SLS_OFS_WAIT) begin
          pend_wait_r <= w_data_r[13:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h00000000;
      case ({s_axi_araddr[7:2], 2'b00})
        `SLS_OFS_SPEED: begin
          s_axi_rdata[`SLS_SPD_P2P_LSB +: 3] <= pend_p2p_r;
          s_axi_rdata[`SLS_SPD_MD_LSB +: 3]  <= pend_md_r;
        end
        `SLS_OFS_ADDR:  s_axi_rdata[6:0]  <= pend_addr_r;
        `SLS_OFS_PROTO: s_axi_rdata[1:0]  <= pend_proto_r;
        `SLS_OFS_FRAME: s_axi_rdata[2:0]  <= pend_frame_r;
        `SLS_OFS_WAIT:  s_axi_rdata[13:0] <= pend_wait_r;
        `SLS_OFS_ACTIVE: begin
          s_axi_rdata[`SLS_ACT_P2P_LSB +: 3]   <= eff_code(act_p2p_r, act_proto_r);
          s_axi_rdata[`SLS_ACT_MD_LSB +: 3]    <= eff_code(act_md_r, act_proto_r);
          s_axi_rdata[`SLS_ACT_PROTO_LSB +: 2] <= act_proto_r;
          s_axi_rdata[`SLS_ACT_FRAME_LSB +: 3] <= act_frame_r;
          s_axi_rdata[`SLS_ACT_ADDR_LSB +: 7]  <= act_addr_r;
          s_axi_rdata[`SLS_ACT_FLAGS_LSB +: 4] <= {reply_waiting_r, md_modbus_en_r,
                                                  p2p_modbus_en_r, addr_valid_r};
        end
        default: s_axi_rresp <= 2'h2;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sls_link_setup

`default_nettype wire

// ---- bench/sls_link_setup_asserts.sv ----
// Purpose: Port checks for the serial link setup block
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Attached by bind, watches design ports, both inputs and outputs
`timescale 1ns/1ps
`default_nettype none
module sls_link_setup_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       p2p_tick16_r,
  input wire logic       p2p_bit_tick_r,
  input wire logic       md_tick16_r,
  input wire logic       md_bit_tick_r,
  input wire logic       p2p_modbus_en_r,
  input wire logic       md_modbus_en_r,
  input wire logic       addr_valid_r,
  input wire logic       reply_request,
  input wire logic       reply_waiting_r,
  input wire logic [3:0] data_bits
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Sample ticks seen since the last bit tick
  logic [3:0] md_sub_cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      md_sub_cnt <= 4'h0;
    end else if (md_tick16_r) begin
      md_sub_cnt <= md_bit_tick_r ? 4'h0 : md_sub_cnt + 4'h1;
    end
  end
  // ----
  // Assertions
  // ----
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  chk_bit_on_tick: assert property (md_bit_tick_r |-> md_tick16_r)
    else $error("bit tick without sample tick");
  chk_p2p_bit_tick: assert property (p2p_bit_tick_r |-> p2p_tick16_r)
    else $error("p2p bit tick without sample tick");
  chk_md_bit_count: assert property (md_bit_tick_r |-> md_sub_cnt == 4'hf)
    else $error("bit tick not on sixteenth sample tick");
  chk_tick_spacing: assert property (md_tick16_r |=> !md_tick16_r [*8])
    else $error("sample ticks too close");
  chk_eight_bits: assert property (data_bits == 4'h8)
    else $error("character length not eight");
  chk_one_modbus: assert property (!(p2p_modbus_en_r && md_modbus_en_r))
    else $error("Modbus on both links");
  chk_mb_addr: assert property (p2p_modbus_en_r || md_modbus_en_r |-> addr_valid_r)
    else $error("Modbus enabled with invalid address");
  chk_wait_start: assert property (reply_request && !reply_waiting_r &&
    (p2p_modbus_en_r || md_modbus_en_r) |=> reply_waiting_r)
    else $error("reply wait did not start");
  cover property (reply_request && md_modbus_en_r);
  cover property (md_bit_tick_r);
  cover property (p2p_modbus_en_r);
endmodule // sls_link_setup_chk
bind sls_link_setup sls_link_setup_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .p2p_tick16_r, .p2p_bit_tick_r, .md_tick16_r,
  .md_bit_tick_r, .p2p_modbus_en_r,
  .md_modbus_en_r, .addr_valid_r, .reply_request, .reply_waiting_r, .data_bits);
`default_nettype wire

// ---- bench/sls_host_model.sv ----
// Purpose: Host side: raises Modbus requests, times replies and ticks
// Assumes: go is a one-cycle pulse from the bench
// Notes:   Latency counts edges from the edge raising request to the one raising release
`timescale 1ns/1ps
`default_nettype none
module sls_host_model (
  input  wire logic aclk,
  input  wire logic go,
  input  wire logic reply_release,
  input  wire logic md_tick16_r,
  input  wire logic p2p_tick16_r,
  output var  logic reply_request,
  output var  int   latency,
  output var  int   tick_gap,
  output var  int   p2p_gap
);
  int cnt = 0;
  int tcnt = 0;
  int pcnt = 0;
  initial reply_request = 1'b0;
  initial latency = 0;
  initial tick_gap = 0;
  initial p2p_gap = 0;
  always @(posedge aclk) begin
    reply_request <= go;
    if (reply_release) begin
      latency <= cnt;
      cnt <= 0;
    end else if (reply_request || cnt != 0) begin
      cnt <= cnt + 1;
    end
    if (md_tick16_r) begin
      tick_gap <= tcnt + 1;
      tcnt <= 0;
    end else begin
      tcnt <= tcnt + 1;
    end
    if (p2p_tick16_r) begin
      p2p_gap <= pcnt + 1;
      pcnt <= 0;
    end else begin
      pcnt <= pcnt + 1;
    end
  end
endmodule // sls_host_model
`default_nettype wire

// ---- bench/sls_link_setup_tb.sv ----
// Purpose: Self-checking bench for the serial link setup block
// Assumes: CYC_PER_MS shortened to 10, wstrb tied to a full word
// Notes:   Model keeps pending and active settings apart
`timescale 1ns/1ps
`default_nettype none
`include "sls_defs.vh"
module sls_link_setup_tb;
  logic        aclk, aresetn, ctrl_power_up, go, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, lfsr_q, d;
  logic        awready, wready, arready, bvalid, rvalid, reply_request, reply_release;
  logic        waiting, p2p_tick, p2p_bit, md_tick, md_bit, p2p_en, md_en, addr_valid, two_stop;
  logic [1:0]  bresp, rresp, parity_mode, r;
  logic [3:0]  data_bits;
  int          errors, num_checks, cyc, latency, tick_gap, p2p_gap;
  int          pend[5], act[5];
  sls_link_setup #(.CYC_PER_MS(10)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctrl_power_up(ctrl_power_up), .reply_request(reply_request),
    .reply_release(reply_release), .reply_waiting_r(waiting), .p2p_tick16_r(p2p_tick),
    .p2p_bit_tick_r(p2p_bit), .md_tick16_r(md_tick), .md_bit_tick_r(md_bit),
    .p2p_modbus_en_r(p2p_en), .md_modbus_en_r(md_en), .addr_valid_r(addr_valid),
    .parity_mode_r(parity_mode), .two_stop_r(two_stop), .data_bits(data_bits));
  sls_host_model host (.aclk(aclk), .go(go), .reply_release(reply_release),
    .md_tick16_r(md_tick), .p2p_tick16_r(p2p_tick), .reply_request(reply_request),
    .latency(latency), .tick_gap(tick_gap), .p2p_gap(p2p_gap));
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  // ----
  // Model
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int eff(input int c);
    return (act[2] == 0 && c == 7) ? 2 : c;
  endfunction
  function automatic logic [2:0] flags();
    return {act[2] == 2 && act[1] != 0, act[2] == 1 && act[1] != 0,
            act[2] == 0 ? act[1] <= 31 : act[1] != 0};
  endfunction
  function automatic logic [31:0] active_word();
    return eff(act[0] & 7) | (eff(act[0] >> 4 & 7) << 4) | (act[2] << 8) | (act[3] << 12)
           | (act[1] << 16) | (32'(flags()) << 24);
  endfunction
  function automatic int divisor(input int c);
    int b;
    b = c < 5 ? 2400 << c : c == 5 ? 57600 : c == 6 ? 115200 : 230400;
    return (100000000 + 8 * b) / (16 * b);
  endfunction
  // Rate error against nominal: 0.5 percent to 38400, 2 percent above
  function automatic logic rate_ok(input int g, input int c);
    longint b, e;
    b = c < 5 ? 2400 << c : c == 5 ? 57600 : c == 6 ? 115200 : 230400;
    e = 100000000 - longint'(g) * 16 * b;
    if (e < 0) e = -e;
    return e * (c < 5 ? 200 : 50) <= 100000000;
  endfunction
  // ----
  // Bus and check tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready; w = wvalid && wready; b = bvalid; r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check(r, er);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      ar = arvalid && arready; v = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask
  task automatic apply(input int s, a, p, f);
    wr(`SLS_OFS_SPEED, s, 2'h0);
    wr(`SLS_OFS_ADDR, a, 2'h0);
    wr(`SLS_OFS_PROTO, p, 2'h0);
    wr(`SLS_OFS_FRAME, f, 2'h0);
    pend[0] = s;
    pend[1] = a;
    pend[2] = p;
    pend[3] = f;
  endtask
  task automatic power_up();
    @(posedge aclk) ctrl_power_up <= 1'b1;
    repeat (6) @(posedge aclk);
    ctrl_power_up <= 1'b0;
    repeat (2) @(posedge aclk);
    act = pend;
  endtask
  task automatic check_ports();
    check({parity_mode, two_stop, md_en, p2p_en, addr_valid},
          {2'(act[3] / 2), 1'(act[3] % 2), flags()});
  endtask
  // Gap is only trusted once a few ticks passed at the new rate
  task automatic wait_ticks();
    int k, j, n;
    k = 0;
    j = 0;
    for (n = 0; n < 10000 && (k < 3 || j < 3); n++) begin
      @(negedge aclk);
      if (md_tick) k++;
      if (p2p_tick) j++;
    end
  endtask
  task automatic fire();
    int n;
    @(posedge aclk) go <= 1'b1;
    @(posedge aclk) go <= 1'b0;
    for (n = 0; n < 200 && !reply_release; n++) @(negedge aclk);
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      end_of_test();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    {ctrl_power_up, go, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    aresetn = 1'b0; errors = 0; num_checks = 0; cyc = 0; lfsr_q = 32'he592f295;
    pend = '{32'h22, 1, 0, 0, 0};
    act = pend;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), pend[i]);
    rdc(`SLS_OFS_ACTIVE, active_word());
    check_ports();
    $display("test reset_values done");
    apply(32'h77, 40, 0, 3);
    rdc(`SLS_OFS_ACTIVE, active_word());
    power_up();
    rdc(`SLS_OFS_ACTIVE, active_word());
    wait_ticks();
    check(tick_gap, divisor(2));
    check(p2p_gap, divisor(2));
    $display("test latch_native done");
    wr(`SLS_OFS_PROTO, 3, 2'h2);
    wr(`SLS_OFS_FRAME, 6, 2'h2);
    wr(`SLS_OFS_WAIT, 10001, 2'h2);
    wr(8'h18, 1, 2'h2);
    rd(8'h18);
    check({d[29:0], r}, 32'h2);
    rdc(`SLS_OFS_PROTO, pend[2]);
    wr(`SLS_OFS_WAIT, 10000, 2'h0);
    $display("test refusals done");
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      apply(i == 2 ? 32'h77 : lfsr_q & 32'h77, i == 0 || i == 4 ? 0 : i == 1 ? 31 : i == 2 ? 32
            : i == 3 ? 127 : lfsr_q[14:8], i % 3, i % 6);
      power_up();
      rdc(`SLS_OFS_ACTIVE, active_word());
      check_ports();
      wait_ticks();
      check(tick_gap, divisor(eff(act[0] >> 4 & 7)));
      check(p2p_gap, divisor(eff(act[0] & 7)));
      check(rate_ok(tick_gap, eff(act[0] >> 4 & 7)), 1'b1);
      check(rate_ok(p2p_gap, eff(act[0] & 7)), 1'b1);
    end
    $display("test random_configs done");
    apply(32'h22, 5, 2, 0);
    wr(`SLS_OFS_WAIT, 0, 2'h0);
    power_up();
    fire();
    check(latency, 2);
    wr(`SLS_OFS_WAIT, 3, 2'h0);
    power_up();
    fire();
    check(latency, 2 + 3 * 10);
    $display("test reply_wait done");
    end_of_test();
  end
endmodule // sls_link_setup_tb
`default_nettype wire
